/* File: core/via_pkg.sv */
/*
 Constants, register offsets and the vector state type shared by the
 interrupt arbiter and its two helper modules.
 Assumes an 8-bit register port with a 3-bit word address.
*/
`default_nettype none

package via_pkg;

    // Register word addresses
    localparam logic [2:0] REG_WAKE_ENABLE = 3'h0;
    localparam logic [2:0] REG_WAKE_EDGE = 3'h1;
    localparam logic [2:0] REG_WAKE_PEND = 3'h2;
    localparam logic [2:0] REG_CTRL = 3'h3;
    localparam logic [2:0] REG_ACTIVE_LO = 3'h4;
    localparam logic [2:0] REG_ACTIVE_HI = 3'h5;

    // Control register fields
    localparam int CTRL_GIE_BIT = 0;
    localparam int CTRL_WAKE_IE_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    // Vectoring
    localparam logic [7:0] VEC_BASE = 8'hE0;
    localparam logic [7:0] TRAP_OPCODE = 8'h00;
    localparam logic [14:0] SERVICE_ENTRY = 15'h00FF;
    localparam logic [3:0] SLOT_TRAP = 4'hF;
    localparam logic [3:0] SLOT_EXT = 4'hD;
    localparam logic [3:0] SLOT_WAKE = 4'h1;
    localparam logic [3:0] SLOT_DEFAULT = 4'h0;
    // Maskable slots fed from outside (wake slot is internal)
    localparam logic [15:0] EXT_SRC_MASK = 16'h3E3C;

    // Stack and program space
    localparam logic [7:0] STACK_LIMIT = 8'h6F;
    localparam logic [7:0] STACK_STEP = 8'h02;
    localparam logic [14:0] STACK_EMPTY_PC = 15'h7FFF;
    localparam int STACK_AW = 4;
    localparam int ADDR_W = 15;
    localparam logic [14:0] PROG_SIZE = 15'h4000;
    localparam logic [14:0] ADDR_ONE = 15'h0001;

    typedef enum logic [1:0] {
        VIS_IDLE = 2'b00,
        VIS_HI = 2'b01,
        VIS_LO = 2'b10,
        VIS_LOAD = 2'b11
    } via_vis_e;

    // Highest set bit wins; no bit gives the default slot
    function automatic logic [3:0] via_top_slot(input logic [15:0] act);
        logic [3:0] s;
        s = SLOT_DEFAULT;
        for (int i = 0; i < 16; i++) begin
            if (act[i]) begin
                s = 4'(i);
            end
        end
        return s;
    endfunction

endpackage

`default_nettype wire

/* File: core/via_wake.sv */
/*
 Eight wake-port inputs: synchroniser, edge select and pending latches.
 Assumes pins are asynchronous; clear mask comes from a register write.
*/
`timescale 1ns/100ps
`default_nettype none

module via_wake
    import via_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] falling_sel_in,
    input wire logic [7:0] clear_in,
    output logic [7:0] pending_out
);

    logic [7:0] sync1_ff;
    logic [7:0] sync2_ff;
    logic [7:0] prev_ff;
    logic [2:0] fill_ff;
    logic [7:0] pend_ff;
    wire logic armed = fill_ff[2];
    wire logic [7:0] rise = sync2_ff & ~prev_ff;
    wire logic [7:0] fall = prev_ff & ~sync2_ff;
    wire logic [7:0] hit = ((falling_sel_in & fall) | (~falling_sel_in & rise)) & {8{armed}};

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_ff <= 8'h00;
            sync2_ff <= 8'h00;
            prev_ff <= 8'h00;
            fill_ff <= 3'h0;
        end else if (ce_in) begin
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
            fill_ff <= {fill_ff[1:0], 1'b1};
        end
    end

    // Set beats clear so an edge during a clear is kept
    generate
        for (genvar i = 0; i < 8; i++) begin : g_pend
            always_ff @(posedge clock_in or posedge rst_in) begin
                if (rst_in) begin
                    pend_ff[i] <= 1'b0;
                end else if (ce_in) begin
                    pend_ff[i] <= hit[i] | (pend_ff[i] & ~clear_in[i]);
                end
            end
        end
    endgenerate

    assign pending_out = pend_ff;

endmodule // via_wake

`default_nettype wire

/* File: core/via_stack_mem.sv */
/*
 Return-address stack storage, one write and one registered read port.
 Assumes the caller keeps indices inside the depth.
*/
`timescale 1ns/100ps
`default_nettype none

module via_stack_mem
    import via_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic wr_in,
    input wire logic [STACK_AW-1:0] waddr_in,
    input wire logic [ADDR_W-1:0] wdata_in,
    input wire logic [STACK_AW-1:0] raddr_in,
    output logic [ADDR_W-1:0] rdata_out
);

    logic [ADDR_W-1:0] mem [0:(1<<STACK_AW)-1];
    logic [ADDR_W-1:0] rdata_ff;

    always_ff @(posedge clock_in) begin
        if (ce_in && wr_in) begin
            mem[waddr_in] <= wdata_in;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_ff <= '0;
        end else if (ce_in) begin
            rdata_ff <= mem[raddr_in];
        end
    end

    assign rdata_out = rdata_ff;

endmodule // via_stack_mem

`default_nettype wire

/* File: core/via_arbiter.sv */
/*
 Vectored interrupt arbiter: trap flag, maskable acknowledge, vector fetch,
 return stack and wake-port registers.
 Assumes the core sequencer on the same clock stalls while a vector fetch
 or a stack pop is in flight, and issues one instruction event per cycle.
*/
// Implementation choices: strobed register access and the address map.
// What this block does
// - Vector select yields even byte E0 to FE
// - Trap gives FE, external pin FA
// - Offset replaces only the counter low byte
// - Fetch vector word, load program counter
// - Trap flag set on trap, reset clears
// - Trap flag has no software access path
// - Clear-trap instruction clears the flag unless a trap fetch comes in the same cycle
// - Zero opcode raises immediate top-priority trap
// - Missing program memory reads as zero
// - Stack underflow past 06F loads 7FFF
// - Trap keeps enable, blocks maskable acknowledge
// - Only another trap enters a trap routine
// - Trap pushes the trap opcode address
// - Eight edge wake inputs, one vector
// - Per-pin wake enable register
// - Per-pin rising or falling edge select
// - Per-pin pending latch, no summary flag
// - Wake request needs both enable flags
// - Wake without interrupt resumes next instruction
// - Maskable never preempts routine; trap may
// - Nothing active selects bottom default vector
// - Acknowledge branches to entry 00FF
// - Interrupt return sets enable, pops address
`timescale 1ns/100ps
`default_nettype none

module via_arbiter
    import via_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // Register port
    input wire logic [2:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Core sequencer
    input wire logic instr_load_in,
    input wire logic [7:0] instr_opcode_in,
    input wire logic [14:0] instr_addr_in,
    input wire logic inst_boundary_in,
    input wire logic [14:0] ret_addr_in,
    input wire logic [14:0] cur_pc_in,
    input wire logic exec_vis_in,
    input wire logic exec_clear_trap_in,
    input wire logic exec_interrupt_return_instruction_in,
    input wire logic exec_skip_return_instruction_in,
    input wire logic lowpower_in,
    input wire logic fetch_rd_in,
    input wire logic [14:0] fetch_addr_in,
    output logic fetch_valid_out,
    output logic [7:0] fetch_data_out,
    output logic pc_load_out,
    output logic [14:0] pc_value_out,
    output logic trap_opcode_instruction_take_out,
    output logic trap_active_out,
    output logic gie_out,
    output logic wake_out,
    // Program memory
    output logic prog_rd_out,
    output logic [14:0] prog_addr_out,
    input wire logic [7:0] prog_data_in,
    // Peripheral sources
    input wire logic [15:0] src_pend_in,
    input wire logic [15:0] src_en_in,
    input wire logic [7:0] wake_pin_in
);

    via_vis_e state_ff;
    via_vis_e nxt_state;
    logic trap_ff;
    logic gie_ff;
    logic wake_ie_ff;
    logic in_service_ff;
    logic [7:0] wake_en_ff;
    logic [7:0] wake_edge_ff;
    logic [7:0] sp_ff;
    logic [14:0] vec_addr_ff;
    logic [7:0] vec_hi_ff;
    logic pop_wait_ff;
    logic pop_skip_ff;
    logic [1:0] fetch_wait_ff;
    logic [14:0] prog_addr_d_ff;
    logic [7:0] reg_rdata_ff;
    logic pc_load_ff;
    logic [14:0] pc_value_ff;
    logic trap_opcode_instruction_take_ff;
    logic prog_rd_ff;
    logic [14:0] prog_addr_ff;
    logic fetch_valid_ff;
    logic [7:0] fetch_data_ff;
    logic wake_ff;
    logic [7:0] wake_pend;
    logic [14:0] pop_data;

    // Trap detection and maskable activity
    wire logic trap_fetch = instr_load_in && (instr_opcode_in == TRAP_OPCODE);
    wire logic [7:0] wake_hits = wake_pend & wake_en_ff;
    wire logic wake_req = (|wake_hits) && wake_ie_ff;
    wire logic [15:0] ext_act = src_pend_in & src_en_in & EXT_SRC_MASK;
    wire logic [15:0] wake_vec = {14'h0000, wake_req, 1'b0};
    wire logic [15:0] mask_act = (ext_act | wake_vec) & {16{~trap_ff}};
    wire logic [15:0] act = mask_act | {trap_ff, 15'h0000};
    wire logic [3:0] slot = via_top_slot(act);
    wire logic [7:0] vec_offset = VEC_BASE | {3'h0, slot, 1'b0};

    // Instruction events, one taken per cycle
    wire logic idle = (state_ff == VIS_IDLE) && !pop_wait_ff;
    wire logic maskable_take = inst_boundary_in && gie_ff && !trap_ff && !in_service_ff
                               && (|mask_act) && idle && !trap_fetch;
    wire logic vis_go = exec_vis_in && idle && !trap_fetch && !maskable_take;
    wire logic ret_go = (exec_interrupt_return_instruction_in || exec_skip_return_instruction_in) && idle && !trap_fetch && !maskable_take && !vis_go;
    wire logic fetch_go = fetch_rd_in && (state_ff == VIS_IDLE) && !vis_go;
    wire logic push_wr = trap_fetch || maskable_take;
    wire logic [14:0] push_data = trap_fetch ? instr_addr_in : ret_addr_in;

    // Stack pointer arithmetic: two bytes per entry, growing down from the limit
    wire logic underflow = (sp_ff >= STACK_LIMIT);
    wire logic [7:0] sp_down = sp_ff - STACK_STEP;
    wire logic [7:0] sp_up = sp_ff + STACK_STEP;
    wire logic [7:0] push_diff = STACK_LIMIT - sp_ff;
    wire logic [7:0] pop_diff = STACK_LIMIT - sp_up;
    wire logic [STACK_AW-1:0] push_idx = push_diff[STACK_AW:1];
    wire logic [STACK_AW-1:0] pop_idx = pop_diff[STACK_AW:1];

    // Reads of absent program memory come back as zero
    wire logic [7:0] prog_data = (prog_addr_d_ff >= PROG_SIZE) ? 8'h00 : prog_data_in;

    // Register decode; the trap flag has no address here
    wire logic reg_sel_en = (reg_addr_in == REG_WAKE_ENABLE);
    wire logic reg_sel_edge = (reg_addr_in == REG_WAKE_EDGE);
    wire logic reg_sel_pend = (reg_addr_in == REG_WAKE_PEND);
    wire logic reg_sel_ctrl = (reg_addr_in == REG_CTRL);
    wire logic [7:0] wake_clear = (reg_wr_in && reg_sel_pend) ? reg_wdata_in : 8'h00;
    wire logic [7:0] ctrl_rd = {6'h00, wake_ie_ff, gie_ff};
    wire logic [7:0] rd_mux = reg_sel_en ? wake_en_ff :
                              reg_sel_edge ? wake_edge_ff :
                              reg_sel_pend ? wake_pend :
                              reg_sel_ctrl ? ctrl_rd :
                              (reg_addr_in == REG_ACTIVE_LO) ? mask_act[7:0] :
                              (reg_addr_in == REG_ACTIVE_HI) ? mask_act[15:8] : 8'h00;

    via_wake u_wake (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .pin_in(wake_pin_in),
        .falling_sel_in(wake_edge_ff),
        .clear_in(wake_clear),
        .pending_out(wake_pend)
    );

    via_stack_mem u_stack (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .wr_in(push_wr),
        .waddr_in(push_idx),
        .wdata_in(push_data),
        .raddr_in(pop_idx),
        .rdata_out(pop_data)
    );

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            VIS_IDLE: begin
                if (vis_go) begin
                    nxt_state = VIS_HI;
                end
            end
            VIS_HI: nxt_state = VIS_LO;
            VIS_LO: nxt_state = VIS_LOAD;
            VIS_LOAD: nxt_state = VIS_IDLE;
        endcase
    end

    // Trap flag: set wins over the clear instruction
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            trap_ff <= 1'b0;
        end else if (ce_in) begin
            trap_ff <= trap_fetch || (trap_ff && !exec_clear_trap_in);
        end
    end

    // Enables and service state
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            gie_ff <= CTRL_RESET[CTRL_GIE_BIT];
            wake_ie_ff <= CTRL_RESET[CTRL_WAKE_IE_BIT];
            in_service_ff <= 1'b0;
            wake_en_ff <= 8'h00;
            wake_edge_ff <= 8'h00;
        end else if (ce_in) begin
            if (reg_wr_in && reg_sel_en) begin
                wake_en_ff <= reg_wdata_in;
            end
            if (reg_wr_in && reg_sel_edge) begin
                wake_edge_ff <= reg_wdata_in;
            end
            if (reg_wr_in && reg_sel_ctrl) begin
                wake_ie_ff <= reg_wdata_in[CTRL_WAKE_IE_BIT];
            end
            // Hardware moves of the enable take precedence over a write
            if (maskable_take) begin
                gie_ff <= 1'b0;
            end else if (ret_go && exec_interrupt_return_instruction_in) begin
                gie_ff <= 1'b1;
            end else if (reg_wr_in && reg_sel_ctrl) begin
                gie_ff <= reg_wdata_in[CTRL_GIE_BIT];
            end
            if (maskable_take) begin
                in_service_ff <= 1'b1;
            end else if (ret_go) begin
                in_service_ff <= 1'b0;
            end
        end
    end

    // Stack pointer and pop tracking; push overflow wraps the storage
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            sp_ff <= STACK_LIMIT;
            pop_wait_ff <= 1'b0;
            pop_skip_ff <= 1'b0;
        end else if (ce_in) begin
            pop_wait_ff <= ret_go && !underflow;
            pop_skip_ff <= exec_skip_return_instruction_in;
            if (push_wr) begin
                sp_ff <= sp_down;
            end else if (ret_go && !underflow) begin
                sp_ff <= sp_up;
            end
        end
    end

    // Vector fetch sequence
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff <= VIS_IDLE;
            vec_addr_ff <= '0;
            vec_hi_ff <= 8'h00;
        end else if (ce_in) begin
            state_ff <= nxt_state;
            if (vis_go) begin
                vec_addr_ff <= {cur_pc_in[14:8], vec_offset};
            end
            if (state_ff == VIS_LO) begin
                vec_hi_ff <= prog_data;
            end
        end
    end

    // Program memory port shared by vector and instruction fetch
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            prog_rd_ff <= 1'b0;
            prog_addr_ff <= '0;
            prog_addr_d_ff <= '0;
            fetch_wait_ff <= 2'h0;
            fetch_valid_ff <= 1'b0;
            fetch_data_ff <= 8'h00;
        end else if (ce_in) begin
            prog_addr_d_ff <= prog_addr_ff;
            fetch_wait_ff <= {fetch_wait_ff[0], fetch_go};
            fetch_valid_ff <= fetch_wait_ff[1];
            fetch_data_ff <= fetch_wait_ff[1] ? prog_data : 8'h00;
            if (vis_go) begin
                prog_rd_ff <= 1'b1;
                prog_addr_ff <= {cur_pc_in[14:8], vec_offset};
            end else if (state_ff == VIS_HI) begin
                prog_rd_ff <= 1'b1;
                prog_addr_ff <= vec_addr_ff + ADDR_ONE;
            end else if (fetch_go) begin
                prog_rd_ff <= 1'b1;
                prog_addr_ff <= fetch_addr_in;
            end else begin
                prog_rd_ff <= 1'b0;
            end
        end
    end

    // Program counter loads toward the core
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pc_load_ff <= 1'b0;
            pc_value_ff <= '0;
            trap_opcode_instruction_take_ff <= 1'b0;
        end else if (ce_in) begin
            trap_opcode_instruction_take_ff <= push_wr;
            pc_load_ff <= push_wr || vis_go || (state_ff == VIS_LOAD) || pop_wait_ff || (ret_go && underflow);
            if (push_wr) begin
                pc_value_ff <= SERVICE_ENTRY;
            end else if (vis_go) begin
                pc_value_ff <= {cur_pc_in[14:8], vec_offset};
            end else if (state_ff == VIS_LOAD) begin
                pc_value_ff <= {vec_hi_ff[6:0], prog_data};
            end else if (pop_wait_ff) begin
                pc_value_ff <= pop_skip_ff ? (pop_data + ADDR_ONE) : pop_data;
            end else if (ret_go && underflow) begin
                pc_value_ff <= STACK_EMPTY_PC;
            end
        end
    end

    // Register read data and wake indication
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_ff <= 8'h00;
            wake_ff <= 1'b0;
        end else if (ce_in) begin
            reg_rdata_ff <= reg_rd_in ? rd_mux : 8'h00;
            wake_ff <= lowpower_in && (|wake_hits);
        end
    end

    assign reg_rdata_out = reg_rdata_ff;
    assign pc_load_out = pc_load_ff;
    assign pc_value_out = pc_value_ff;
    assign trap_opcode_instruction_take_out = trap_opcode_instruction_take_ff;
    assign trap_active_out = trap_ff;
    assign gie_out = gie_ff;
    assign wake_out = wake_ff;
    assign prog_rd_out = prog_rd_ff;
    assign prog_addr_out = prog_addr_ff;
    assign fetch_valid_out = fetch_valid_ff;
    assign fetch_data_out = fetch_data_ff;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    sequence vis_run_s;
        (vis_go && ce_in) ##1 ce_in ##1 ce_in ##1 ce_in;
    endsequence

    vis_offset_a: assert property ((vis_go && ce_in) |=> prog_rd_out && prog_addr_out[7:0] == $past(vec_offset)
                                   && prog_addr_out[0] == 1'b0)
        else $error("vector offset wrong");
    trap_rank_a: assert property (trap_ff |-> vec_offset == 8'hFE)
        else $error("trap not top rank");
    ext_rank_a: assert property ((!trap_ff && ext_act[13]) |-> vec_offset == 8'hFA)
        else $error("external rank wrong");
    pc_high_a: assert property ((vis_go && ce_in) |=> pc_load_out && pc_value_out[14:8] == $past(cur_pc_in[14:8]))
        else $error("pc high byte changed");
    vis_load_a: assert property (vis_run_s |=> pc_load_out && state_ff == VIS_IDLE
                                 && pc_value_out[7:0] == $past(prog_data))
        else $error("vector not loaded");
    trap_set_a: assert property ((trap_fetch && ce_in) |=> trap_ff && trap_opcode_instruction_take_out
                                 && pc_value_out == SERVICE_ENTRY)
        else $error("trap not raised");
    trap_clear_a: assert property ((exec_clear_trap_in && !trap_fetch && ce_in) |=> !trap_ff)
        else $error("trap flag not cleared");
    trap_hold_a: assert property ((trap_ff && !exec_clear_trap_in) |=> trap_ff)
        else $error("trap flag lost");
    gie_keep_a: assert property ((trap_fetch && ce_in) |=> gie_ff == $past(gie_ff))
        else $error("trap touched enable");
    mask_block_a: assert property ((trap_ff || in_service_ff) |-> !maskable_take)
        else $error("maskable taken while blocked");
    entry_a: assert property ((maskable_take && ce_in) |=> pc_load_out && pc_value_out == SERVICE_ENTRY
                              && !gie_ff && in_service_ff)
        else $error("bad acknowledge");
    underflow_a: assert property ((ret_go && underflow && ce_in) |=> pc_load_out
                                  && pc_value_out == STACK_EMPTY_PC)
        else $error("underflow not trapped");
    fetch_zero_a: assert property ((fetch_go && fetch_addr_in >= PROG_SIZE && ce_in) ##1 ce_in ##1 ce_in
                                   |=> fetch_valid_out && fetch_data_out == 8'h00)
        else $error("absent memory not zero");
    interrupt_return_instruction_gie_a: assert property ((ret_go && exec_interrupt_return_instruction_in && ce_in) |=> gie_ff)
        else $error("return left enable low");

endmodule // via_arbiter

`default_nettype wire

/* File: tb/via_prog_model.sv */
/*
 Program memory model for the arbiter's vector and fetch read port.
 Assumes the arbiter wants each byte in the cycle after its read strobe.
*/
`timescale 1ns/100ps
`default_nettype none
module via_prog_model (
    input wire logic clock_in,
    input wire logic prog_rd_in,
    input wire logic [14:0] prog_addr_in,
    output logic [7:0] prog_data_out
);
    initial prog_data_out = 8'h5A;
    // Idle bus toggles, so a stale byte is never mistaken for data
    always @(posedge clock_in) begin
        prog_data_out <= prog_rd_in ? prog_addr_in[7:0] + 8'h11 : ~prog_data_out;
    end
endmodule // via_prog_model
`default_nettype wire

/* File: tb/tb_vectored_interrupt_arbiter.sv */
/*
 Self-checking bench: trap flag, vectoring, returns, wake port, fetch.
 Assumes via_prog_model as program memory and the arbiter's own assertions.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_vectored_interrupt_arbiter;
    import via_pkg::*;
    logic clock_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, lowpower_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic [6:0] evs = 7'h00;
    logic [2:0] reg_addr_in = 3'h0;
    logic [7:0] reg_wdata_in = 8'h00, instr_opcode_in = 8'h42, wake_pin_in = 8'h00;
    logic [14:0] instr_addr_in = 15'h0123, ret_addr_in = 15'h0456, cur_pc_in = 15'h0, fetch_addr_in = 15'h0;
    logic [15:0] src_pend_in = 16'h2000, src_en_in = 16'h0000;
    logic [7:0] reg_rdata_out, fetch_data_out, prog_data_in;
    logic [14:0] pc_value_out, prog_addr_out;
    logic fetch_valid_out, pc_load_out, trap_opcode_instruction_take_out, trap_active_out, gie_out, wake_out, prog_rd_out;
    int fail_count = 0, check_count = 0;
    via_arbiter DUT (.clock_in, .rst_in, .ce_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
        .reg_rdata_out, .instr_load_in(evs[4]), .instr_opcode_in, .instr_addr_in, .inst_boundary_in(evs[5]),
        .ret_addr_in, .cur_pc_in, .exec_vis_in(evs[0]), .exec_clear_trap_in(evs[1]), .exec_interrupt_return_instruction_in(evs[2]),
        .exec_skip_return_instruction_in(evs[3]), .lowpower_in, .fetch_rd_in(evs[6]), .fetch_addr_in, .fetch_valid_out,
        .fetch_data_out, .pc_load_out, .pc_value_out, .trap_opcode_instruction_take_out, .trap_active_out, .gie_out,
        .wake_out, .prog_rd_out, .prog_addr_out, .prog_data_in, .src_pend_in, .src_en_in, .wake_pin_in);
    via_prog_model MEM (.clock_in, .prog_rd_in(prog_rd_out), .prog_addr_in(prog_addr_out),
        .prog_data_out(prog_data_in));
    initial begin
        forever #50 clock_in = ~clock_in;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One core event for one cycle; returns just after the answer edge
    task automatic ev(input int k, input logic [7:0] opc = 8'h42);
        @(posedge clock_in);
        instr_opcode_in <= opc;
        evs[k] <= 1'b1;
        @(posedge clock_in);
        evs <= 7'h00;
        #1;
    endtask
    task automatic pc_at(input int n, input logic [14:0] exp);
        repeat (n) @(posedge clock_in);
        #1;
        chk({pc_load_out, pc_value_out}, {1'b1, exp});
    endtask
    task automatic reg_op(input logic wr, input logic [2:0] a, input logic [7:0] d);
        @(posedge clock_in);
        reg_wr_in <= wr;
        reg_rd_in <= !wr;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clock_in);
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
        #1;
        if (!wr) chk({8'h00, reg_rdata_out}, {8'h00, d});
    endtask
    // Model byte is address low byte plus 11, high byte first
    task automatic vector_select_instruction(input logic [14:0] pc, input logic [7:0] off);
        logic [7:0] hi;
        hi = off + 8'h11;
        @(posedge clock_in);
        cur_pc_in <= pc;
        ev(0);
        pc_at(0, {pc[14:8], off});
        pc_at(3, {hi[6:0], hi + 8'h01});
    endtask
    task automatic t_trap;
        reg_op(1'b1, REG_CTRL, 8'h01);
        ev(4);
        chk(16'(trap_active_out), 16'h0000);
        ev(4, TRAP_OPCODE);
        chk({trap_opcode_instruction_take_out, pc_value_out}, 16'h80FF);
        chk(16'({trap_active_out, gie_out}), 16'h0003);
        reg_op(1'b0, REG_CTRL, 8'h01);
        @(posedge clock_in) src_en_in <= 16'h2000;
        ev(5);
        chk(16'(trap_opcode_instruction_take_out), 16'h0000);
        vector_select_instruction(15'h0100, 8'hFE);
        ev(1);
        chk(16'(trap_active_out), 16'h0000);
        // Enable low first, so the return has to raise it
        reg_op(1'b1, REG_CTRL, 8'h00);
        ev(2);
        pc_at(1, 15'h0123);
        chk(16'(gie_out), 16'h0001);
    endtask
    task automatic t_mask;
        ev(5);
        chk({trap_opcode_instruction_take_out, pc_value_out}, 16'h80FF);
        ev(5);
        chk(16'(trap_opcode_instruction_take_out), 16'h0000);
        vector_select_instruction(15'h0100, 8'hFA);
        ev(4, TRAP_OPCODE);
        chk(16'(trap_opcode_instruction_take_out), 16'h0001);
        ev(1);
        ev(3);
        pc_at(1, 15'h0124);
        ev(3);
        pc_at(1, 15'h0457);
        ev(3);
        pc_at(0, 15'h7FFF);
        @(posedge clock_in) src_en_in <= 16'h0000;
    endtask
    // Pin 1 selects falling edge and pin 0 rising: both pins must latch
    task automatic t_wake;
        reg_op(1'b1, REG_WAKE_ENABLE, 8'h01);
        reg_op(1'b1, REG_WAKE_EDGE, 8'h02);
        reg_op(1'b1, REG_CTRL, 8'h01);
        @(posedge clock_in) wake_pin_in <= 8'h02;
        repeat (6) @(posedge clock_in);
        wake_pin_in <= 8'h01;
        repeat (6) @(posedge clock_in);
        reg_op(1'b0, REG_WAKE_PEND, 8'h03);
        @(posedge clock_in) lowpower_in <= 1'b1;
        @(posedge clock_in) lowpower_in <= 1'b0;
        #1;
        chk(16'(wake_out), 16'h0001);
        ev(5);
        chk(16'(trap_opcode_instruction_take_out), 16'h0000);
        reg_op(1'b1, REG_CTRL, 8'h03);
        ev(5);
        chk(16'(trap_opcode_instruction_take_out), 16'h0001);
        vector_select_instruction(15'h0200, 8'hE2);
        reg_op(1'b1, REG_WAKE_PEND, 8'h01);
        reg_op(1'b0, REG_WAKE_PEND, 8'h02);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clock_in);
        rst_in <= 1'b0;
        #1;
        chk(16'({trap_active_out, gie_out}), 16'h0000);
        reg_op(1'b0, REG_CTRL, 8'h00);
        reg_op(1'b0, 3'h7, 8'h00);
        vector_select_instruction(15'h0200, 8'hE0);
        t_trap();
        t_mask();
        t_wake();
        @(posedge clock_in) fetch_addr_in <= 15'h5000;
        ev(6);
        repeat (2) @(posedge clock_in);
        #1;
        chk({7'h00, fetch_valid_out, fetch_data_out}, 16'h0100);
        summarize();
    end
    // Whole run is under 200 cycles; this is ample
    initial begin
        #1000000;
        fail_count++;
        summarize();
    end
endmodule // tb_vectored_interrupt_arbiter
`default_nettype wire
